// ### logic/coil_drive_consts.vh
// constants for the coil drive control word decoder
`ifndef COIL_DRIVE_CONSTS_VH
`define COIL_DRIVE_CONSTS_VH
`define WORD_BITS 20
`define ADDR_HI_BIT 19
`define ADDR_LO_BIT 18
`define CDC_ADDR 2'h0
`define POL_A_BIT 17
`define MAG_A_HI 16
`define MAG_A_LO 9
`define POL_B_BIT 8
`define MAG_B_HI 7
`define MAG_B_LO 0
`define INTERP_BIT 9
`define DUAL_EDGE_BIT 8
`define RES_HI 3
`define RES_LO 0
`define RES_FULL_STEP 4'h8
`define STEPS_MAX 9'h100
`define STEPS_MIN 9'h001
`define RES_RESET 4'h0
`define MAG_RESET 8'h00
`define FLAG_RESET 1'b0
`define MAG_BITS 8
`define RES_BITS 4
`define COUNT_BITS 9
`define PIN_COUNT 3
`define PIN_SCK 0
`define PIN_SDI 1
`define PIN_SEL 2
`define SCK_IDLE 1'b0
`define SDI_IDLE 1'b0
`define SEL_IDLE 1'b1
`endif

// ### logic/coil_drive_control_decode.v
// serial port receiver and decoder for the coil drive control word
`timescale 1ns/1ps
`include "coil_drive_consts.vh"

// How it works
// - top two bits zero selects this register
// - disable set: direct per-coil current layout
// - disable clear: step interface configuration layout
// - bit 17 is coil A polarity
// - bits 16..9 coil A magnitude
// - bit 8 is coil B polarity
// - bits 7..0 coil B magnitude
// - bit 9 enables sixteenfold step interpolation
// - bit 8 enables dual edge stepping
// - bits 3..0 select microsteps, 256 to 1
// - latch last 20 bits at select rise
// - disable bit arrives as an input
module coil_drive_control_decode (
    input wire clk, // system clock, 250 MHz
    input wire rst, // synchronous reset, active high
    input wire sck, // serial clock from host
    input wire sdi, // serial data from host
    input wire cs_n, // chip select from host, active low
    input wire step_input_disable, // layout select from driver configuration
    output reg coil_a_polarity, // direct mode coil A sign
    output reg [7:0] coil_a_magnitude, // direct mode coil A current
    output reg coil_b_polarity, // direct mode coil B sign
    output reg [7:0] coil_b_magnitude, // direct mode coil B current
    output reg step_interpolation_enable, // step mode interpolation
    output reg dual_edge_step, // step mode dual edge
    output reg [3:0] microstep_resolution, // step mode resolution code
    output reg [8:0] microsteps_per_quarter, // decoded microsteps per 90 degrees
    output reg step_inputs_enabled, // step/direction inputs honoured
    output reg word_strobe // one-cycle pulse on each accepted word
);
    parameter WORD_BITS = `WORD_BITS;
    parameter MAG_BITS = `MAG_BITS;
    parameter RES_BITS = `RES_BITS;
    parameter COUNT_BITS = `COUNT_BITS;
    parameter PIN_COUNT = `PIN_COUNT;

    // ****************************************
    // pin synchronisers
    // ****************************************
    // every host pin is asynchronous to clk; each one passes two stages
    wire [PIN_COUNT-1:0] pin_raw;
    wire [PIN_COUNT-1:0] pin_idle;
    wire [PIN_COUNT-1:0] pin_sync;
    reg [PIN_COUNT-1:0] pin_prev;
    wire sck_rise;
    wire cs_rise;
    wire sel;
    wire sdi_bit;

    assign pin_raw[`PIN_SCK] = sck;
    assign pin_raw[`PIN_SDI] = sdi;
    assign pin_raw[`PIN_SEL] = cs_n;

    // reset to idle levels so no false edge follows reset
    assign pin_idle[`PIN_SCK] = `SCK_IDLE;
    assign pin_idle[`PIN_SDI] = `SDI_IDLE;
    assign pin_idle[`PIN_SEL] = `SEL_IDLE;

    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_sync
            reg meta;
            reg stable;
            always @(posedge clk) begin
                if (rst) begin
                    meta <= pin_idle[g];
                    stable <= pin_idle[g];
                end else begin
                    meta <= pin_raw[g];
                    stable <= meta;
                end
            end
            assign pin_sync[g] = stable;
        end
    endgenerate

    // ****************************************
    // edge detection
    // ****************************************
    always @(posedge clk) begin
        if (rst) begin
            pin_prev <= pin_idle;
        end else begin
            pin_prev <= pin_sync;
        end
    end

    assign sck_rise = pin_sync[`PIN_SCK] & ~pin_prev[`PIN_SCK];
    assign cs_rise = pin_sync[`PIN_SEL] & ~pin_prev[`PIN_SEL];
    // sdi goes through the same two stages as sck, so they stay aligned
    assign sdi_bit = pin_sync[`PIN_SDI];
    assign sel = ~pin_sync[`PIN_SEL];

    // ****************************************
    // shift register
    // ****************************************
    reg [WORD_BITS-1:0] shift;
    reg [WORD_BITS-1:0] next_shift;

    // longer frames just push older bits out the top
    always @* begin
        next_shift = shift;
        if (sel && sck_rise) begin
            next_shift = {shift[WORD_BITS-2:0], sdi_bit};
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            shift <= {WORD_BITS{1'b0}};
        end else begin
            shift <= next_shift;
        end
    end

    // ****************************************
    // field extraction
    // ****************************************
    // pure function of code; codes above full step saturate at one
    function [COUNT_BITS-1:0] steps_of;
        input [RES_BITS-1:0] code;
        begin
            if (code > `RES_FULL_STEP) begin
                steps_of = `STEPS_MIN;
            end else begin
                steps_of = `STEPS_MAX >> code;
            end
        end
    endfunction

    wire [1:0] word_addr;
    wire word_is_ctrl;
    wire latch_direct;
    wire latch_step;
    wire field_pol_a;
    wire [MAG_BITS-1:0] field_mag_a;
    wire field_pol_b;
    wire [MAG_BITS-1:0] field_mag_b;
    wire field_interp;
    wire field_dual;
    wire [RES_BITS-1:0] field_res;
    wire [COUNT_BITS-1:0] field_steps;

    assign word_addr = {shift[`ADDR_HI_BIT], shift[`ADDR_LO_BIT]};
    assign word_is_ctrl = cs_rise && (word_addr == `CDC_ADDR);
    // the layout bit is sampled only at latch time
    assign latch_direct = word_is_ctrl && step_input_disable;
    assign latch_step = word_is_ctrl && !step_input_disable;

    assign field_pol_a = shift[`POL_A_BIT];
    assign field_mag_a = shift[`MAG_A_HI:`MAG_A_LO];
    assign field_pol_b = shift[`POL_B_BIT];
    assign field_mag_b = shift[`MAG_B_HI:`MAG_B_LO];
    // reserved bits are not checked; the host keeps them zero
    assign field_interp = shift[`INTERP_BIT];
    assign field_dual = shift[`DUAL_EDGE_BIT];
    assign field_res = shift[`RES_HI:`RES_LO];
    assign field_steps = steps_of(field_res);

    // ****************************************
    // next values
    // ****************************************
    reg next_coil_a_polarity;
    reg [MAG_BITS-1:0] next_coil_a_magnitude;
    reg next_coil_b_polarity;
    reg [MAG_BITS-1:0] next_coil_b_magnitude;
    reg next_step_interpolation_enable;
    reg next_dual_edge_step;
    reg [RES_BITS-1:0] next_microstep_resolution;
    reg [COUNT_BITS-1:0] next_microsteps_per_quarter;
    reg next_step_inputs_enabled;
    reg next_word_strobe;

    // each layout leaves the other's fields alone
    always @* begin
        next_coil_a_polarity = coil_a_polarity;
        next_coil_a_magnitude = coil_a_magnitude;
        next_coil_b_polarity = coil_b_polarity;
        next_coil_b_magnitude = coil_b_magnitude;
        next_step_interpolation_enable = step_interpolation_enable;
        next_dual_edge_step = dual_edge_step;
        next_microstep_resolution = microstep_resolution;
        next_microsteps_per_quarter = microsteps_per_quarter;
        next_step_inputs_enabled = step_inputs_enabled;
        next_word_strobe = `FLAG_RESET;
        if (word_is_ctrl) begin
            next_word_strobe = 1'b1;
            next_step_inputs_enabled = ~step_input_disable;
        end
        if (latch_direct) begin
            next_coil_a_polarity = field_pol_a;
            next_coil_a_magnitude = field_mag_a;
            next_coil_b_polarity = field_pol_b;
            next_coil_b_magnitude = field_mag_b;
        end
        if (latch_step) begin
            next_step_interpolation_enable = field_interp;
            next_dual_edge_step = field_dual;
            next_microstep_resolution = field_res;
            next_microsteps_per_quarter = field_steps;
        end
    end

    // ****************************************
    // output registers
    // ****************************************
    always @(posedge clk) begin
        if (rst) begin
            coil_a_polarity <= `FLAG_RESET;
            coil_a_magnitude <= `MAG_RESET;
            coil_b_polarity <= `FLAG_RESET;
            coil_b_magnitude <= `MAG_RESET;
            step_interpolation_enable <= `FLAG_RESET;
            dual_edge_step <= `FLAG_RESET;
            microstep_resolution <= `RES_RESET;
            microsteps_per_quarter <= `STEPS_MAX;
            step_inputs_enabled <= `FLAG_RESET;
            word_strobe <= `FLAG_RESET;
        end else begin
            coil_a_polarity <= next_coil_a_polarity;
            coil_a_magnitude <= next_coil_a_magnitude;
            coil_b_polarity <= next_coil_b_polarity;
            coil_b_magnitude <= next_coil_b_magnitude;
            step_interpolation_enable <= next_step_interpolation_enable;
            dual_edge_step <= next_dual_edge_step;
            microstep_resolution <= next_microstep_resolution;
            microsteps_per_quarter <= next_microsteps_per_quarter;
            step_inputs_enabled <= next_step_inputs_enabled;
            word_strobe <= next_word_strobe;
        end
    end
endmodule // coil_drive_control_decode

// ### tb/spi_host_model.sv
// host side serial master model for the control port
`timescale 1ns/1ps
module spi_host_model (
    input wire clk, // system clock
    output logic sck = 0, // still outside frames
    output logic sdi = 0, // msb first
    output logic cs_n = 1 // select, low active
);
    // host keeps reserved bits zero and magnitudes within 248
    task automatic frame(input logic [31:0] w, input int n);
        @(negedge clk) cs_n = 0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            repeat (4) @(negedge clk);
            sck = 1;
            repeat (4) @(negedge clk);
            sck = 0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1;
        sdi = ~sdi; // released line must not look held
    endtask
endmodule // spi_host_model

// ### tb/coil_drive_control_properties.sv
// port checks for the coil drive control decoder
`timescale 1ns/1ps
module coil_drive_control_properties (
    input wire clk, // clock
    input wire rst, // reset
    input wire cs_n, // select
    input wire step_input_disable, // layout
    input wire [7:0] coil_a_magnitude, // coil a
    input wire coil_b_polarity, // coil b
    input wire [3:0] microstep_resolution, // code
    input wire [8:0] microsteps_per_quarter, // decoded
    input wire step_inputs_enabled, // mode
    input wire word_strobe // accepted
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence quiet3; !word_strobe [*3]; endsequence
    strobe_once_a: assert property (word_strobe |=> quiet3)
        else $error("strobe too long");
    strobe_cs_a: assert property (word_strobe |-> $past(cs_n, 2))
        else $error("strobe inside frame");
    mag_a_mode_a: assert property ($changed(coil_a_magnitude) |-> !step_inputs_enabled)
        else $error("magnitude in step mode");
    pol_b_mode_a: assert property ($changed(coil_b_polarity) |-> !step_inputs_enabled)
        else $error("polarity in step mode");
    microstep_resolution_mode_a: assert property ($changed(microstep_resolution) |-> step_inputs_enabled)
        else $error("resolution in direct mode");
    mpq_value_a: assert property ($stable(microstep_resolution) |-> microsteps_per_quarter ==
        (microstep_resolution > 4'h8 ? 9'h1 : 9'h100 >> microstep_resolution))
        else $error("microstep count wrong");
    step_on_a: assert property ($rose(step_inputs_enabled) |-> !$past(step_input_disable, 3))
        else $error("mode rose wrongly");
    step_off_a: assert property ($fell(step_inputs_enabled) |-> $past(step_input_disable, 3))
        else $error("mode fell wrongly");
endmodule // coil_drive_control_properties
bind coil_drive_control_decode coil_drive_control_properties i_coil_drive_control_properties (.*);

// ### tb/tb_coil_drive_control_decode.sv
// self-checking bench for the coil drive control decoder
`timescale 1ns/1ps
module tb_coil_drive_control_decode;
    logic clk = 0, rst = 1, step_input_disable = 1, seen;
    wire sck, sdi, cs_n, coil_a_polarity, coil_b_polarity, step_interpolation_enable;
    wire dual_edge_step, step_inputs_enabled, word_strobe;
    wire [7:0] coil_a_magnitude, coil_b_magnitude;
    wire [3:0] microstep_resolution;
    wire [8:0] microsteps_per_quarter;
    int n_mismatch = 0, cmp_count = 0, cycles = 0;
    coil_drive_control_decode i_coil_drive_control_decode (.*);
    spi_host_model i_spi_host_model (.*);
    always #2 clk = ~clk;
    always @(posedge clk) if (++cycles == 20000) begin n_mismatch++; wrap_up(); end
    task automatic wr(input logic d, input logic [31:0] w, input int n);
        step_input_disable = d;
        i_spi_host_model.frame(w, n);
        seen = 0;
        repeat (8) @(negedge clk) seen |= word_strobe;
        repeat (4) @(negedge clk);
    endtask
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
        end
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 0;
        repeat (4) @(negedge clk);
        wr(1'h1, 32'h3f001, 20);
        chk(seen, 9'h1);
        chk(coil_a_polarity, 9'h1);
        chk(coil_a_magnitude, 9'hf8);
        chk(coil_b_polarity, 9'h0);
        chk(coil_b_magnitude, 9'h1);
        chk(step_inputs_enabled, 9'h0);
        for (int c = 0; c < 10; c++) begin
            wr(1'h0, {c[0], c[1], 4'h0, c[3:0]}, 20);
            chk(step_interpolation_enable, c[0]);
            chk(dual_edge_step, c[1]);
            chk(microsteps_per_quarter, c > 8 ? 9'h1 : 9'h100 >> c);
            chk(coil_a_magnitude, 9'hf8);
            chk(step_inputs_enabled, 9'h1);
        end
        wr(1'h1, 32'hf00381, 24); // leading nibble must be dropped
        chk(coil_b_polarity, 9'h1);
        chk(coil_b_magnitude, 9'h81);
        chk(microstep_resolution, 9'h9);
        wr(1'h1, 32'h40000, 20);
        chk(seen, 9'h0);
        chk(coil_a_magnitude, 9'h1);
        wrap_up();
    end
endmodule // tb_coil_drive_control_decode
